// File: rtl/ssc_top.sv
`default_nettype none
// How it works
// - Select high means standby; bus ignored and outputs released.
// - Nothing runs until a select falling edge starts a sequence.
// - Opcode 03h reads memory, 02h writes, from the following address.
// - 3Bh enters dual width, 38h quad, FFh back to single.
// - 05h reads the mode register, 01h writes it.
// - A 24-bit address is taken; only its low 17 bits are used.
// - Read shifts out the addressed byte, then the next ones in sequence.
// - Sequential pointer wraps from the top address to zero.
// - A rising select ends whatever command is running.
// - Page writes keep incrementing inside the 32-byte page, overwriting.
// - Sequential writes cross page boundaries and wrap around the array.
// - Mode bits 7:6: 00 byte, 10 page, 01 sequential; sequential default.
// - Mode bits 5:0 read back as zero.
// - Mode register readable any time, eight bits, MSB first.
// - Mode write stores the mode field, steering later increments.
// - Inputs sampled on rising clock edges; outputs change after falling.
// - Lines zero and one turn bidirectional in dual and quad widths.
// - Dual moves two bits, quad a nibble, per clock, MSBs first.
// - Line three is pause in single and dual, data in quad.
// - Pause changes take effect at a low clock or the next falling edge.
// - While paused, clock and data are ignored and state is kept.
// - Output releases at pause and drives again on its release at once.
// - Byte mode moves exactly one data byte after the address.
// - Page mode pointer wraps to the start of the same page.
// - Opcode, address and data all travel MSB first.
module ssc_top
   import ssc_pkg::*;
#(
   parameter int AW = ADDR_BITS
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic serial_clk,
   input wire logic data_line_zero_i,
   output logic data_line_zero_o,
   output logic data_line_zero_oe,
   input wire logic data_line_one_i,
   output logic data_line_one_o,
   output logic data_line_one_oe,
   input wire logic data_line_two_i,
   output logic data_line_two_o,
   output logic data_line_two_oe,
   input wire logic pause_or_data_line_three_i,
   output logic pause_or_data_line_three_o,
   output logic pause_or_data_line_three_oe
);
   ////////////////////////////////////////////////////////////////////////////
   logic [5:0] pins_s;
   logic cs_n_s;
   logic sck_s;
   logic [3:0] din_s;
   logic sck_d_r;
   logic cs_n_d_r;
   logic rise;
   logic fall;
   logic cs_fall;

   // Select travels inverted so the cleared synchroniser reads as deselected.
   ssc_sync #(.W(6)) u_sync
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .din({!chip_select_n, serial_clk, pause_or_data_line_three_i, data_line_two_i,
            data_line_one_i, data_line_zero_i}),
      .dout(pins_s)
   );

   assign cs_n_s = !pins_s[5];
   assign sck_s = pins_s[4];
   assign din_s = pins_s[3:0];

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sck_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end
      else
      begin
         sck_d_r <= sck_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   assign cs_fall = cs_n_d_r && !cs_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // Pause handling.
   ssc_width_t width_r;
   logic paused_r;
   logic pause_req;

   assign pause_req = (width_r != WID_QUAD) && !din_s[3];

   // A change while the clock is low acts at once, else it waits for a fall.
   always_ff @(posedge sys_clk)
   begin
      if (rst || cs_n_s)
      begin
         paused_r <= 1'b0;
      end
      else if (!sck_s || (sck_d_r && !sck_s))
      begin
         paused_r <= pause_req;
      end
   end

   // Edges are masked while paused so the sequence state is frozen.
   assign rise = !cs_n_s && !paused_r && sck_s && !sck_d_r;
   assign fall = !cs_n_s && !paused_r && !sck_s && sck_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer.
   ssc_mem_if #(.AW(AW)) mif ();

   ssc_mem #(.AW(AW)) u_mem
   (
      .sys_clk(sys_clk),
      .bus(mif.mem)
   );

   ssc_state_t state_r;
   logic active_r;
   logic [7:0] shin_r;
   logic [5:0] cnt_r;
   logic [7:0] opcode_r;
   logic [AW-1:0] ptr_r;
   logic [1:0] mode_r;
   logic [7:0] shout_r;
   logic load_r;
   logic drive_r;
   logic we_r;
   logic [7:0] wdata_r;
   logic [AW-1:0] waddr_r;
   logic done_r;
   logic [2:0] step;
   logic [7:0] shin_nxt;
   logic [5:0] cnt_nxt;
   logic [AW-1:0] ptr_inc;

   assign step = ssc_step(width_r);

   // New bits enter at the bottom, so the first bit lands at the top.
   always_comb
   begin
      unique case (width_r)
         WID_DUAL: shin_nxt = {shin_r[5:0], din_s[1:0]};
         WID_QUAD: shin_nxt = {shin_r[3:0], din_s};
         default: shin_nxt = {shin_r[6:0], din_s[0]};
      endcase
   end

   assign cnt_nxt = cnt_r + {3'h0, step};

   always_comb
   begin
      unique case (mode_r)
         MODE_PAGE: ptr_inc = {ptr_r[AW-1:PAGE_BITS], ptr_r[PAGE_BITS-1:0] + 1'b1};
         default: ptr_inc = ptr_r + 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_r <= ST_OPCODE;
         active_r <= 1'b0;
         shin_r <= 8'h00;
         cnt_r <= 6'h00;
         opcode_r <= 8'h00;
         ptr_r <= '0;
         width_r <= WID_SINGLE;
         mode_r <= MODE_RESET;
         load_r <= 1'b0;
         we_r <= 1'b0;
         wdata_r <= 8'h00;
         waddr_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         we_r <= 1'b0;
         if (cs_n_s)
         begin
            load_r <= 1'b0;
            state_r <= ST_OPCODE;
            active_r <= 1'b0;
            cnt_r <= 6'h00;
            done_r <= 1'b0;
         end
         else if (cs_fall)
         begin
            active_r <= 1'b1;
            state_r <= ST_OPCODE;
            cnt_r <= 6'h00;
         end
         else if (rise && active_r)
         begin
            shin_r <= shin_nxt;
            cnt_r <= cnt_nxt;
            unique case (state_r)
               ST_OPCODE:
               begin
                  if (cnt_nxt == 6'd8)
                  begin
                     cnt_r <= 6'h00;
                     opcode_r <= shin_nxt;
                     state_r <= ST_IGNORE;
                     unique case (shin_nxt)
                        OP_READ, OP_WRITE: state_r <= ST_ADDR;
                        OP_RDMODE: state_r <= ST_RMODE;
                        OP_WRMODE: state_r <= ST_WMODE;
                        OP_DUAL: width_r <= WID_DUAL;
                        OP_QUAD: width_r <= WID_QUAD;
                        OP_SINGLE: width_r <= WID_SINGLE;
                        default: state_r <= ST_IGNORE;
                     endcase
                  end
               end
               ST_ADDR:
               begin
                  // Top seven address bits simply fall off the pointer.
                  unique case (width_r)
                     WID_DUAL: ptr_r <= AW'({ptr_r, din_s[1:0]});
                     WID_QUAD: ptr_r <= AW'({ptr_r, din_s});
                     default: ptr_r <= AW'({ptr_r, din_s[0]});
                  endcase
                  if (cnt_nxt == 6'(ADDR_XFER_BITS))
                  begin
                     cnt_r <= 6'h00;
                     state_r <= (opcode_r == OP_READ) ? ST_RDATA : ST_WDATA;
                     load_r <= (opcode_r == OP_READ);
                  end
               end
               ST_WDATA:
               begin
                  if (cnt_nxt == 6'd8)
                  begin
                     cnt_r <= 6'h00;
                     we_r <= 1'b1;
                     wdata_r <= shin_nxt;
                     waddr_r <= ptr_r;
                     ptr_r <= ptr_inc;
                     if (mode_r == MODE_BYTE)
                     begin
                        state_r <= ST_IGNORE;
                     end
                  end
               end
               ST_RDATA, ST_RMODE:
               begin
                  if (cnt_nxt == 6'd8)
                  begin
                     cnt_r <= 6'h00;
                     if (state_r == ST_RMODE || mode_r == MODE_BYTE)
                     begin
                        done_r <= 1'b1;
                     end
                     else
                     begin
                        load_r <= 1'b1;
                     end
                  end
               end
               ST_WMODE:
               begin
                  if (cnt_nxt == 6'd8)
                  begin
                     mode_r <= shin_nxt[MODE_HI:MODE_LO];
                     state_r <= ST_IGNORE;
                  end
               end
               default: state_r <= ST_IGNORE;
            endcase
         end
         else if (fall && load_r)
         begin
            ptr_r <= ptr_inc;
            load_r <= 1'b0;
         end
      end
   end

   assign mif.addr = we_r ? waddr_r : ptr_r;
   assign mif.we = we_r;
   assign mif.wdata = wdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Output shifter: a memory byte enters on the fall that must show its top bit; the mode word on the rise before.
   logic [7:0] mode_word;

   assign mode_word = {mode_r, 6'h00};

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         shout_r <= 8'h00;
         drive_r <= 1'b0;
      end
      else if (cs_n_s)
      begin
         drive_r <= 1'b0;
      end
      else
      begin
         if (rise && state_r == ST_OPCODE && cnt_nxt == 6'd8 && shin_nxt == OP_RDMODE)
         begin
            shout_r <= mode_word;
         end
         else if (fall && load_r)
         begin
            // The pointer has been still since the last rise, so the read data are settled.
            shout_r <= mif.rdata;
         end
         else if (fall && drive_r)
         begin
            unique case (width_r)
               WID_DUAL: shout_r <= {shout_r[5:0], 2'b00};
               WID_QUAD: shout_r <= {shout_r[3:0], 4'h0};
               default: shout_r <= {shout_r[6:0], 1'b0};
            endcase
         end
         if (fall)
         begin
            // First bit appears after the falling edge that ends the preamble.
            drive_r <= (state_r == ST_RDATA || state_r == ST_RMODE) && !done_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins; all registered. Enables fall with pause at once.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         data_line_zero_o <= 1'b0;
         data_line_zero_oe <= 1'b0;
         data_line_one_o <= 1'b0;
         data_line_one_oe <= 1'b0;
         data_line_two_o <= 1'b0;
         data_line_two_oe <= 1'b0;
         pause_or_data_line_three_o <= 1'b0;
         pause_or_data_line_three_oe <= 1'b0;
      end
      else
      begin
         data_line_zero_o <= (width_r == WID_QUAD) ? shout_r[4] : shout_r[6];
         data_line_one_o <= (width_r == WID_QUAD) ? shout_r[5] : shout_r[7];
         data_line_two_o <= shout_r[6];
         pause_or_data_line_three_o <= shout_r[7];
         data_line_one_oe <= drive_r && !cs_n_s && !pause_req;
         data_line_zero_oe <= drive_r && !cs_n_s && !pause_req && width_r != WID_SINGLE;
         data_line_two_oe <= drive_r && !cs_n_s && width_r == WID_QUAD;
         pause_or_data_line_three_oe <= drive_r && !cs_n_s && width_r == WID_QUAD;
      end
   end
endmodule : ssc_top
`default_nettype wire

// File: pkg/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_DUAL = 8'h3B;
   localparam logic [7:0] OP_QUAD = 8'h38;
   localparam logic [7:0] OP_SINGLE = 8'hFF;
   localparam logic [7:0] OP_RDMODE = 8'h05;
   localparam logic [7:0] OP_WRMODE = 8'h01;
   localparam int ADDR_BITS = 17;
   localparam int ADDR_XFER_BITS = 24;
   localparam int PAGE_BITS = 5;
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam logic [1:0] MODE_BYTE = 2'h0;
   localparam logic [1:0] MODE_PAGE = 2'h2;
   localparam logic [1:0] MODE_SEQ = 2'h1;
   localparam logic [1:0] MODE_RESET = MODE_SEQ;
   localparam int LINK_PERIOD_NS = 125;
   localparam int CLK_PERIOD_NS = 8;
   localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;

   typedef enum logic [1:0]
   {
      WID_SINGLE = 2'b00,
      WID_DUAL = 2'b01,
      WID_QUAD = 2'b10
   } ssc_width_t;

   typedef enum logic [2:0]
   {
      ST_OPCODE = 3'b000,
      ST_ADDR = 3'b001,
      ST_RDATA = 3'b010,
      ST_WDATA = 3'b011,
      ST_RMODE = 3'b100,
      ST_WMODE = 3'b101,
      ST_IGNORE = 3'b110
   } ssc_state_t;

   // Bits moved per serial clock for the given bus width.
   function automatic logic [2:0] ssc_step(input ssc_width_t w);
      unique case (w)
         WID_DUAL: ssc_step = 3'h2;
         WID_QUAD: ssc_step = 3'h4;
         default: ssc_step = 3'h1;
      endcase
   endfunction : ssc_step
endpackage : ssc_pkg
`default_nettype wire

// File: pkg/ssc_mem_if.sv
`default_nettype none
interface ssc_mem_if #(parameter int AW = 17);
   logic [AW-1:0] addr;
   logic we;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctl (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface : ssc_mem_if
`default_nettype wire

// File: rtl/ssc_sync.sv
`default_nettype none
module ssc_sync
   import ssc_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // The first stage is seen only by the second.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         meta_r <= '0;
         dout <= '0;
      end
      else
      begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule : ssc_sync
`default_nettype wire

// File: rtl/ssc_mem.sv
`default_nettype none
module ssc_mem
   import ssc_pkg::*;
#(
   parameter int AW = 17
)
(
   input wire logic sys_clk,
   ssc_mem_if.mem bus
);
   logic [7:0] ram_r [0:(1<<AW)-1];

   // Registered read; the contents are not reset, as in a real array.
   always_ff @(posedge sys_clk)
   begin
      if (bus.we)
      begin
         ram_r[bus.addr] <= bus.wdata;
      end
      bus.rdata <= ram_r[bus.addr];
   end
endmodule : ssc_mem
`default_nettype wire

// File: tb/ssc_top_assertions.sv
`default_nettype none
module ssc_top_assertions
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic serial_clk,
   input wire logic pause_or_data_line_three_i,
   input wire logic data_line_zero_oe,
   input wire logic data_line_one_o,
   input wire logic data_line_one_oe,
   input wire logic data_line_two_oe,
   input wire logic pause_or_data_line_three_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic any_oe;
   assign any_oe = data_line_zero_oe | data_line_one_oe | data_line_two_oe
      | pause_or_data_line_three_oe;
   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   sequence sel_idle;
      chip_select_n [*6];
   endsequence
   sequence pause_hit;
      $fell(pause_or_data_line_three_i) && data_line_one_oe && !data_line_two_oe;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   standby_quiet_a: assert property (sel_idle |-> !any_oe)
      else $error("output enabled while deselected");
   end_release_a: assert property ($rose(chip_select_n) |-> ##[1:6] !any_oe)
      else $error("output kept after select rose");
   reset_quiet_a: assert property (disable iff (1'b0) rst |=> !any_oe)
      else $error("output enabled during reset");
   start_quiet_a: assert property ($fell(chip_select_n) |-> !any_oe [*6])
      else $error("output enabled before any command");
   quad_group_a: assert property (data_line_two_oe |-> data_line_zero_oe && data_line_one_oe
      && pause_or_data_line_three_oe)
      else $error("quad lines not driven together");
   dual_pair_a: assert property (data_line_zero_oe |-> data_line_one_oe)
      else $error("line zero driven without line one");
   three_quad_a: assert property (pause_or_data_line_three_oe |-> data_line_two_oe)
      else $error("line three driven outside quad width");
   fall_update_a: assert property (data_line_one_oe && $changed(data_line_one_o)
      |-> !serial_clk)
      else $error("output changed while serial clock high");
   pause_float_a: assert property (pause_hit |-> ##[1:6] !data_line_one_oe)
      else $error("output still driven during pause");
endmodule : ssc_top_assertions
bind ssc_top ssc_top_assertions chk
(
   .sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
   .pause_or_data_line_three_i(pause_or_data_line_three_i),
   .data_line_zero_oe(data_line_zero_oe), .data_line_one_o(data_line_one_o),
   .data_line_one_oe(data_line_one_oe), .data_line_two_oe(data_line_two_oe),
   .pause_or_data_line_three_oe(pause_or_data_line_three_oe)
);
`default_nettype wire

// File: tb/ssc_host_model.sv
`default_nettype none
module ssc_host_model
(
   input wire logic sys_clk,
   output logic chip_select_n,
   output logic serial_clk,
   input wire logic [3:0] dev_o,
   input wire logic [3:0] dev_oe,
   output logic [3:0] lines
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] host_o = 4'h8;
   logic [3:0] host_oe = 4'h8;
   logic pause_n = 1'b1;
   logic drove = 1'b0;
   logic flip = 1'b0;
   initial
   begin
      chip_select_n = 1'b1;
      serial_clk = 1'b0;
   end
   // Released lines toggle every cycle so a stale value can never pass for data.
   always @(posedge sys_clk) flip <= ~flip;
   always_comb
   begin
      for (int k = 0; k < 4; k++)
      begin
         lines[k] = (dev_oe[k] && host_oe[k]) ? 1'bx : dev_oe[k] ? dev_o[k] : host_oe[k] ? host_o[k] : flip;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic start();
      @(negedge sys_clk);
      chip_select_n = 1'b0;
      repeat (8) @(negedge sys_clk);
   endtask : start
   task automatic stop();
      @(negedge sys_clk);
      serial_clk = 1'b0;
      repeat (8) @(negedge sys_clk);
      chip_select_n = 1'b1;
      repeat (8) @(negedge sys_clk);
      // Line three is taken back only once the device has let go of it.
      host_oe = 4'h8;
      host_o = 4'h8;
   endtask : stop
   task automatic xfer(input logic [7:0] tx, input int w, input bit rd, output logic [7:0] rx);
      logic [3:0] nib;
      logic [3:0] m;
      rx = 8'h00;
      m = 4'((1 << w) - 1);
      for (int k = 8 - w; k >= 0; k -= w)
      begin
         @(negedge sys_clk);
         serial_clk = 1'b0;
         nib = 4'(tx >> k);
         host_oe = (w == 4 ? 4'h0 : 4'h8) | (rd ? 4'h0 : m);
         host_o = {w == 4 ? nib[3] : pause_n, nib[2:0]};
         repeat (8) @(negedge sys_clk);
         serial_clk = 1'b1;
         drove = dev_oe[1];
         rx = (w == 1) ? {rx[6:0], lines[1]} : 8'((rx << w) | (lines & m));
         repeat (7) @(negedge sys_clk);
      end
   endtask : xfer
   // Pause is moved only with the clock low; a high clock would delay it a whole edge.
   task automatic hold(output logic gone, output logic back);
      @(negedge sys_clk);
      serial_clk = 1'b0;
      repeat (8) @(negedge sys_clk);
      pause_n = 1'b0;
      host_o[3] = 1'b0;
      repeat (8) @(negedge sys_clk);
      gone = dev_oe[1];
      repeat (2)
      begin
         serial_clk = 1'b1;
         repeat (8) @(negedge sys_clk);
         serial_clk = 1'b0;
         repeat (8) @(negedge sys_clk);
      end
      pause_n = 1'b1;
      host_o[3] = 1'b1;
      repeat (8) @(negedge sys_clk);
      back = dev_oe[1];
   endtask : hold
endmodule : ssc_host_model
`default_nettype wire

// File: tb/ssc_top_bench.sv
`default_nettype none
module ssc_top_bench
   import ssc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n;
   logic sclk;
   logic [3:0] lines;
   logic [3:0] dev_o;
   logic [3:0] dev_oe;
   int failures = 0;
   int tests_run = 0;
   always #4 sys_clk = ~sys_clk;
   ssc_host_model h (.sys_clk(sys_clk), .chip_select_n(cs_n), .serial_clk(sclk),
      .dev_o(dev_o), .dev_oe(dev_oe), .lines(lines));
   ssc_top dut (.sys_clk(sys_clk), .rst(rst), .chip_select_n(cs_n), .serial_clk(sclk),
      .data_line_zero_i(lines[0]), .data_line_zero_o(dev_o[0]), .data_line_zero_oe(dev_oe[0]),
      .data_line_one_i(lines[1]), .data_line_one_o(dev_o[1]), .data_line_one_oe(dev_oe[1]),
      .data_line_two_i(lines[2]), .data_line_two_o(dev_o[2]), .data_line_two_oe(dev_oe[2]),
      .pause_or_data_line_three_i(lines[3]), .pause_or_data_line_three_o(dev_o[3]),
      .pause_or_data_line_three_oe(dev_oe[3]));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic head(input logic [7:0] op, input logic [23:0] a, input int w);
      logic [7:0] z;
      h.start();
      h.xfer(op, w, 1'b0, z);
      if (op == OP_READ || op == OP_WRITE)
      begin
         for (int i = 2; i >= 0; i--)
         begin
            h.xfer(8'(a >> (8 * i)), w, 1'b0, z);
         end
      end
   endtask : head
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nb,
      input logic [15:0] d, input bit rd, input int w, output logic [15:0] r);
      logic [7:0] z;
      r = 16'h0000;
      head(op, a, w);
      for (int i = 0; i < nb; i++)
      begin
         h.xfer(i == 0 ? d[15:8] : d[7:0], w, rd, z);
         r = {r[7:0], z};
      end
      h.stop();
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_mode();
      logic [15:0] r;
      cmd(OP_RDMODE, 24'h0, 1, 16'h0, 1'b1, 1, r);
      chk(r, {8'h00, MODE_RESET, 6'h00});
      cmd(OP_WRMODE, 24'h0, 1, {MODE_PAGE, 14'h0}, 1'b0, 1, r);
      cmd(OP_RDMODE, 24'h0, 1, 16'h0, 1'b1, 1, r);
      chk(r, {8'h00, MODE_PAGE, 6'h00});
      $display("test mode register done");
   endtask : t_mode
   task automatic t_page();
      logic [15:0] r;
      cmd(OP_WRITE, 24'h00043F, 2, 16'h1122, 1'b0, 1, r);
      cmd(OP_READ, 24'h00043F, 2, 16'h0, 1'b1, 1, r);
      chk(r, 16'h1122);
      $display("test page wrap done");
   endtask : t_page
   task automatic t_byte();
      logic [15:0] r;
      cmd(OP_WRMODE, 24'h0, 1, {MODE_BYTE, 14'h0}, 1'b0, 1, r);
      cmd(OP_READ, 24'h00043F, 2, 16'h0, 1'b1, 1, r);
      chk({8'h00, r[15:8]}, 16'h0011);
      chk({15'h0, h.drove}, 16'h0000);
      cmd(OP_WRITE, 24'h00043F, 2, 16'h3344, 1'b0, 1, r);
      cmd(OP_WRMODE, 24'h0, 1, {MODE_SEQ, 14'h0}, 1'b0, 1, r);
      cmd(OP_READ, 24'h00043F, 1, 16'h0, 1'b1, 1, r);
      chk(r, 16'h0033);
      $display("test byte mode done");
   endtask : t_byte
   task automatic t_seq();
      logic [15:0] r;
      cmd(OP_WRITE, 24'hFFFFFF, 2, 16'hA53C, 1'b0, 1, r);
      cmd(OP_READ, 24'h01FFFF, 2, 16'h0, 1'b1, 1, r);
      chk(r, 16'hA53C);
      cmd(OP_READ, 24'h000000, 1, 16'h0, 1'b1, 1, r);
      chk(r, 16'h003C);
      $display("test sequential wrap done");
   endtask : t_seq
   task automatic t_wide();
      logic [15:0] r;
      cmd(OP_DUAL, 24'h0, 0, 16'h0, 1'b0, 1, r);
      cmd(OP_WRITE, 24'h000123, 2, 16'h5AC3, 1'b0, 2, r);
      cmd(OP_READ, 24'h000123, 2, 16'h0, 1'b1, 2, r);
      chk(r, 16'h5AC3);
      cmd(OP_SINGLE, 24'h0, 0, 16'h0, 1'b0, 2, r);
      cmd(OP_QUAD, 24'h0, 0, 16'h0, 1'b0, 1, r);
      cmd(OP_READ, 24'h000123, 2, 16'h0, 1'b1, 4, r);
      chk(r, 16'h5AC3);
      cmd(OP_WRITE, 24'h000124, 1, 16'h9600, 1'b0, 4, r);
      cmd(OP_SINGLE, 24'h0, 0, 16'h0, 1'b0, 4, r);
      cmd(OP_READ, 24'h000123, 2, 16'h0, 1'b1, 1, r);
      chk(r, 16'h5A96);
      $display("test bus widths done");
   endtask : t_wide
   task automatic t_pause();
      logic [7:0] z;
      logic gone;
      logic back;
      head(OP_READ, 24'h01FFFF, 1);
      h.hold(gone, back);
      chk({15'h0, gone}, 16'h0000);
      chk({15'h0, back}, 16'h0001);
      h.xfer(8'h00, 1, 1'b1, z);
      chk({8'h00, z}, 16'h00A5);
      h.stop();
      $display("test pause done");
   endtask : t_pause
   task automatic t_unk();
      logic [7:0] z;
      logic [15:0] r;
      head(8'hAA, 24'h0, 1);
      h.xfer(8'h00, 1, 1'b1, z);
      chk({15'h0, h.drove}, 16'h0000);
      h.stop();
      cmd(OP_RDMODE, 24'h0, 1, 16'h0, 1'b1, 1, r);
      chk(r, {8'h00, MODE_SEQ, 6'h00});
      $display("test unknown opcode done");
   endtask : t_unk
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      t_mode();
      t_page();
      t_byte();
      t_seq();
      t_wide();
      t_pause();
      t_unk();
      finish_test();
   end
   // The whole sequence needs about 90 us; over four times that means a hang.
   initial
   begin
      #400000;
      failures++;
      $display("watchdog expired");
      finish_test();
   end
endmodule : ssc_top_bench
`default_nettype wire
